// [adsq_core_model.sv]
`timescale 1ns/10ps
module adsq_core_model (
  input  wire logic       mclk,                 // Clock
  input  wire logic       nrst,                 // Reset
  input  wire logic       conv_start,           // Start
  input  wire logic [2:0] conv_channel,         // Channel
  input  wire logic [7:0] lat,                  // Answer delay
  output logic            conv_done,            // Done pulse
  output logic      [9:0] channel_sample_value  // Sample
);
  logic       busy_r;
  logic [7:0] cnt_r;
  logic [2:0] ch_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      ch_r <= 3'h0;
      conv_done <= 1'b0;
      channel_sample_value <= 10'h000;
    end else begin
      conv_done <= 1'b0;
      if (conv_start) begin
        busy_r <= 1'b1;
        cnt_r <= lat;
        ch_r <= conv_channel;
      end else if (busy_r && cnt_r == 8'h00) begin
        busy_r <= 1'b0;
        conv_done <= 1'b1;
        channel_sample_value <= {ch_r, 7'h55};
      end else if (busy_r) begin
        cnt_r <= cnt_r - 8'h01;
      // Sample is not held past its strobe
      end else if (conv_done) begin
        channel_sample_value <= ~channel_sample_value;
      end
    end
  end
endmodule

// [adsq_defs.svh]
`ifndef ADSQ_DEFS_SVH
`define ADSQ_DEFS_SVH

// Register byte offsets
`define ADSQ_OFF_CTRL   8'h00
`define ADSQ_OFF_DELAY  8'h04
`define ADSQ_OFF_FLAGS  8'h08
`define ADSQ_OFF_SMASK  8'h0C
`define ADSQ_OFF_RMASK  8'h10
`define ADSQ_OFF_RES0   8'h14
`define ADSQ_OFF_ISTAT  8'h40
`define ADSQ_OFF_ICLR   8'h44
`define ADSQ_OFF_IEN    8'h48

// Control register fields
`define ADSQ_CTL_ACT    0
`define ADSQ_CTL_SSGL   1
`define ADSQ_CTL_SRPT   2
`define ADSQ_CTL_PSD    3
`define ADSQ_CTL_SRST   4
`define ADSQ_CTL_RDONE  5
`define ADSQ_CTL_SDONE  7

// Delay register fields
`define ADSQ_DLY_RPT_HI 31
`define ADSQ_DLY_RPT_LO 16
`define ADSQ_DLY_STA_HI 15
`define ADSQ_DLY_STA_LO 0

// Interrupt status bits
`define ADSQ_IRQ_SDONE  0
`define ADSQ_IRQ_RDONE  1

// Reset values
`define ADSQ_RST_DELAY  32'h0000_0000
`define ADSQ_RST_BYTE   8'h00
`define ADSQ_RST_RES    10'h000

// Timing
`define ADSQ_CLK_MHZ    20
`define ADSQ_TICK_US    40
`define ADSQ_TICK_CYC   (`ADSQ_TICK_US * `ADSQ_CLK_MHZ)

`endif

// [adsq_pkg.sv]
package adsq_pkg;

  typedef enum logic [2:0] {
    ADSQ_IDLE  = 3'b000,
    ADSQ_WAITD = 3'b001,
    ADSQ_PICK  = 3'b011,
    ADSQ_CONV  = 3'b010,
    ADSQ_FIN   = 3'b110
  } adsq_fsm_t;

  typedef enum logic {
    ADSQ_MODE_SINGLE = 1'b0,
    ADSQ_MODE_REPEAT = 1'b1
  } adsq_mode_t;

endpackage

// [adsq_regs.sv]
// Summary of operation
// - Repeat gap between passes, 40us ticks
// - Start delay before first repeat pass
// - Single shot skips both delays
// - Per-channel done flag set on finish
// - Done flags clear on write one
// - Single pass end sets single-done
// - Repeat pass end sets repeat-done
// - Single pass converts single-mask channels only
// - Repeat pass converts repeat-mask channels only
// - Result: 10 low bits, rest zero
// - Unimplemented channel bits reserved, unused
// - Start-single launches one pass, self-clears
// - Clearing start-repeat stops further passes
// - New pass clears its done flag
`timescale 1ns/10ps
`include "adsq_defs.svh"
module adsq_regs #(
  parameter int NUM_CH   = 8,
  parameter int ADDR_W   = 8,
  parameter int TICK_CYC = `ADSQ_TICK_CYC
) (
  input  wire logic              mclk,          // 20 MHz clock
  input  wire logic              nrst,          // Async reset, low
  input  wire logic              psel,          // APB select
  input  wire logic              penable,       // APB enable
  input  wire logic              pwrite,        // APB direction
  input  wire logic [ADDR_W-1:0] paddr,         // APB byte address
  input  wire logic [31:0]       pwdata,        // APB write data
  output logic      [31:0]       prdata,        // APB read data
  output logic                   pready,        // APB ready
  output logic                   pslverr,       // APB error
  output logic                   irq,           // Interrupt level
  output logic                   conv_start,    // Core start pulse
  output logic      [2:0]        conv_channel,  // Core channel
  output logic                   conv_power,    // Core power on
  output logic                   core_reset,    // Core reset
  input  wire logic              conv_done,     // Core done pulse
  input  wire logic [9:0]        channel_sample_value  // Core sample
);
  import adsq_pkg::*;

  // Channels this build implements; the rest are reserved
  localparam logic [7:0] IMPL = 8'((1 << NUM_CH) - 1);

  // Block state bar the tick prescaler in one word; nrst clears all of it
  typedef struct packed {
    adsq_fsm_t        fsm;
    adsq_mode_t       mode;
    logic             act;
    logic             act_prev;
    logic             ssgl;
    logic             srpt;
    logic             psd;
    logic             srst;
    logic             sdone;
    logic             rdone;
    logic [31:0]      delay;
    logic [7:0]       flags;
    logic [7:0]       smask;
    logic [7:0]       rmask;
    logic [7:0][9:0]  res;
    logic [7:0]       pending;
    logic [2:0]       ch;
    logic [15:0]      dcnt;
    logic [1:0]       ist;
    logic [1:0]       ien;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             irq;
    logic             conv_start;
    logic             pwr;
    logic             core_rst;
    logic             restart;
  } adsq_st_t;

  adsq_st_t s_r;
  adsq_st_t s_nxt;

  logic [7:0]  res_hit;
  logic [31:0] res_word [8];

  for (genvar g = 0; g < 8; g++) begin : g_ch
    if (g < NUM_CH) begin : g_impl
      assign res_hit[g]  = (paddr == ADDR_W'(`ADSQ_OFF_RES0 + 4 * g));
      assign res_word[g] = {22'h00_0000, s_r.res[g]};
    end else begin : g_rsvd
      assign res_hit[g]  = 1'b0;
      assign res_word[g] = 32'h0000_0000;
    end
  end

  // One prescaler serves both the start delay and the repeat gap
  adsq_tick_if tk_if ();

  adsq_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .mclk (mclk),
    .nrst (nrst),
    .tk   (tk_if.gen)
  );

  assign tk_if.restart = s_r.restart;

  always_comb begin
    logic [31:0] rd;
    logic        hit;
    logic        wr;
    logic        setup;
    logic [2:0]  sel;
    rd    = 32'h0000_0000;
    hit   = 1'b1;
    setup = psel & ~penable;
    // Write strobe only in the single cycle that pready stands
    wr    = psel & penable & s_r.pready & pwrite;
    sel   = 3'h0;
    s_nxt = s_r;
    s_nxt.pready     = 1'b0;
    s_nxt.pslverr    = 1'b0;
    s_nxt.conv_start = 1'b0;
    s_nxt.restart    = 1'b0;
    s_nxt.act_prev   = s_r.act;
    s_nxt.core_rst   = s_r.srst | (s_r.act & ~s_r.act_prev);

    // Read mux, sampled in the setup cycle
    unique case (paddr)
      `ADSQ_OFF_CTRL:  rd = {24'h00_0000, s_r.sdone, 1'b0, s_r.rdone,
                             s_r.srst, s_r.psd, s_r.srpt, s_r.ssgl,
                             s_r.act};
      `ADSQ_OFF_DELAY: rd = s_r.delay;
      `ADSQ_OFF_FLAGS: rd = {24'h00_0000, s_r.flags};
      `ADSQ_OFF_SMASK: rd = {24'h00_0000, s_r.smask};
      `ADSQ_OFF_RMASK: rd = {24'h00_0000, s_r.rmask};
      `ADSQ_OFF_ISTAT: rd = {30'h0, s_r.ist};
      `ADSQ_OFF_ICLR:  rd = 32'h0000_0000;
      `ADSQ_OFF_IEN:   rd = {30'h0, s_r.ien};
      default:         hit = 1'b0;
    endcase
    for (int i = 0; i < 8; i++) begin
      if (res_hit[i]) begin
        rd  = res_word[i];
        hit = 1'b1;
      end
    end
    // Unmapped reads give zero so no stale word leaks out
    if (setup) begin
      s_nxt.pready  = 1'b1;
      s_nxt.prdata  = hit ? rd : 32'h0000_0000;
      s_nxt.pslverr = ~hit;
    end

    // Register writes take effect at the completing edge
    if (wr) begin
      unique case (paddr)
        // Done bits are write-one-clear, the rest plain
        `ADSQ_OFF_CTRL: begin
          s_nxt.act  = pwdata[`ADSQ_CTL_ACT];
          s_nxt.ssgl = pwdata[`ADSQ_CTL_SSGL];
          s_nxt.srpt = pwdata[`ADSQ_CTL_SRPT];
          s_nxt.psd  = pwdata[`ADSQ_CTL_PSD];
          s_nxt.srst = pwdata[`ADSQ_CTL_SRST];
          if (pwdata[`ADSQ_CTL_RDONE]) begin
            s_nxt.rdone = 1'b0;
          end
          if (pwdata[`ADSQ_CTL_SDONE]) begin
            s_nxt.sdone = 1'b0;
          end
        end
        `ADSQ_OFF_DELAY: s_nxt.delay = pwdata;
        `ADSQ_OFF_FLAGS: s_nxt.flags = s_r.flags & ~pwdata[7:0];
        `ADSQ_OFF_SMASK: s_nxt.smask = pwdata[7:0] & IMPL;
        `ADSQ_OFF_RMASK: s_nxt.rmask = pwdata[7:0] & IMPL;
        // Interrupt clear is write-only and reads zero
        `ADSQ_OFF_ICLR:  s_nxt.ist   = s_r.ist & ~pwdata[1:0];
        `ADSQ_OFF_IEN:   s_nxt.ien   = pwdata[1:0];
        default: ;
      endcase
    end

    // Sequencer; runs after writes so hardware sets win over clears
    if (s_r.srst) begin
      // Sequencer only; the registers keep their values
      s_nxt.fsm     = ADSQ_IDLE;
      s_nxt.pending = 8'h00;
      s_nxt.dcnt    = 16'h0000;
    end else begin
      unique case (s_r.fsm)
        // A single request overrides a running repeat delay
        ADSQ_IDLE, ADSQ_WAITD: begin
          if (s_r.act && s_r.ssgl) begin
            s_nxt.mode    = ADSQ_MODE_SINGLE;
            s_nxt.ssgl    = 1'b0;
            s_nxt.sdone   = 1'b0;
            s_nxt.pending = s_r.smask & IMPL;
            s_nxt.fsm     = ADSQ_PICK;
          end else if (!s_r.act || !s_r.srpt) begin
            s_nxt.fsm = ADSQ_IDLE;
          end else if (s_r.fsm == ADSQ_IDLE) begin
            s_nxt.dcnt    = s_r.delay[`ADSQ_DLY_STA_HI:`ADSQ_DLY_STA_LO];
            s_nxt.restart = 1'b1;
            s_nxt.fsm     = ADSQ_WAITD;
          end else if (s_r.dcnt == 16'h0000) begin
            s_nxt.mode    = ADSQ_MODE_REPEAT;
            s_nxt.rdone   = 1'b0;
            s_nxt.pending = s_r.rmask & IMPL;
            s_nxt.fsm     = ADSQ_PICK;
          // A tick in the restart cycle belongs to the old interval
          end else if (tk_if.tick && !s_r.restart) begin
            s_nxt.dcnt = s_r.dcnt - 16'h0001;
          end
        end
        // Lowest pending channel goes first
        ADSQ_PICK: begin
          for (int i = 7; i >= 0; i--) begin
            if (s_r.pending[i]) begin
              sel = 3'(i);
            end
          end
          if (s_r.pending == 8'h00) begin
            s_nxt.fsm = ADSQ_FIN;
          end else begin
            s_nxt.ch         = sel;
            s_nxt.conv_start = 1'b1;
            s_nxt.fsm        = ADSQ_CONV;
          end
        end
        // The core may take any number of cycles to answer
        ADSQ_CONV: begin
          if (conv_done) begin
            s_nxt.res[s_r.ch]     = channel_sample_value;
            s_nxt.flags[s_r.ch]   = 1'b1;
            s_nxt.pending[s_r.ch] = 1'b0;
            s_nxt.fsm             = ADSQ_PICK;
          end
        end
        ADSQ_FIN: begin
          if (s_r.mode == ADSQ_MODE_SINGLE) begin
            s_nxt.sdone                = 1'b1;
            s_nxt.ist[`ADSQ_IRQ_SDONE] = 1'b1;
          end else begin
            s_nxt.rdone                = 1'b1;
            s_nxt.ist[`ADSQ_IRQ_RDONE] = 1'b1;
          end
          if (s_r.act && s_r.srpt) begin
            s_nxt.dcnt    = s_r.delay[`ADSQ_DLY_RPT_HI:`ADSQ_DLY_RPT_LO];
            s_nxt.restart = 1'b1;
            s_nxt.fsm     = ADSQ_WAITD;
          end else begin
            s_nxt.fsm = ADSQ_IDLE;
          end
        end
        default: s_nxt.fsm = ADSQ_IDLE;
      endcase
    end

    // Next-state values so irq rises with its status bit
    s_nxt.irq = |(s_nxt.ist & s_nxt.ien);
    // Power saver drops the core between passes unless disabled;
    // a pass under way keeps power even after activate is cleared
    s_nxt.pwr = (s_nxt.act & s_nxt.psd) |
                ((s_nxt.fsm != ADSQ_IDLE) && (s_nxt.fsm != ADSQ_WAITD));
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata       = s_r.prdata;
  assign pready       = s_r.pready;
  assign pslverr      = s_r.pslverr;
  assign irq          = s_r.irq;
  assign conv_start   = s_r.conv_start;
  assign conv_channel = s_r.ch;
  assign conv_power   = s_r.pwr;
  assign core_reset   = s_r.core_rst;
endmodule

// [adsq_regs_asserts.sv]
`timescale 1ns/10ps
module adsq_regs_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic              mclk,          // Clock
  input wire logic              nrst,          // Reset
  input wire logic              psel,          // Select
  input wire logic              penable,       // Enable
  input wire logic              pwrite,        // Write
  input wire logic [ADDR_W-1:0] paddr,         // Address
  input wire logic [31:0]       prdata,        // Read data
  input wire logic              pready,        // Ready
  input wire logic              pslverr,       // Error
  input wire logic              conv_start,    // Start
  input wire logic [2:0]        conv_channel,  // Channel
  input wire logic              conv_power     // Power
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire rd_acc = pready && !pwrite;

  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready too long");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error with data");
  a_result_upper: assert property (
    rd_acc && paddr >= 8'h14 && paddr <= 8'h30 |-> prdata[31:10] == 22'h0)
    else $error("result upper bits set");
  a_flag_upper: assert property (
    rd_acc && paddr == 8'h08 |-> prdata[31:8] == 24'h0)
    else $error("flag upper bits set");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start not a pulse");
  a_chan_held: assert property ($changed(conv_channel) |-> conv_start)
    else $error("channel moved");
  a_start_power: assert property (conv_start |-> conv_power)
    else $error("start unpowered");

  cover property (conv_start);
  cover property (pslverr);
  cover property (pready && pwrite);
endmodule

// [adsq_regs_test.sv]
`timescale 1ns/10ps
module adsq_regs_test;
  logic        mclk, nrst, psel, penable, pwrite, err;
  logic [7:0]  paddr, lat;
  logic [31:0] pwdata, prdata, rv;
  logic        pready, pslverr, irq, conv_start, conv_done;
  logic        conv_power, core_reset;
  logic [2:0]  conv_channel;
  logic [9:0]  sample;
  int          n_errors, num_checks, t0, t1, i;
  int          cyc = 0;
  int          n_rst = 0;

  adsq_regs #(.TICK_CYC(4)) uut (.mclk(mclk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_power(conv_power), .core_reset(core_reset),
    .conv_done(conv_done),
    .channel_sample_value(sample));
  adsq_core_model core (.mclk(mclk), .nrst(nrst), .conv_start(conv_start),
    .conv_channel(conv_channel), .lat(lat), .conv_done(conv_done),
    .channel_sample_value(sample));

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    n_rst <= n_rst + int'(core_reset === 1'b1);
    if (cyc == 30000) begin
      n_errors++;
      end_sim;
    end
  end

  task end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  task wait_ctrl(input logic [31:0] m);
    do apb(1'b0, 8'h00, 32'h0); while ((rv & m) !== m);
  endtask
  task wait_start;
    do @(posedge mclk); while (conv_start !== 1'b1);
  endtask

  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {n_errors, num_checks} = '0;
    lat = 8'h28;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    for (i = 4; i <= 48; i += 4) rchk(i[7:0], 32'h0);
    chk({30'h0, conv_power, core_reset}, 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk({err, rv[30:0]}, 32'h8000_0000);
    apb(1'b1, 8'h04, 32'hFFFF_FFFF);
    rchk(8'h04, 32'hFFFF_FFFF);
    // Single mask written while the sequencer is idle; only implemented channel bits are kept
    apb(1'b1, 8'h0C, 32'hFFFF_FF81);
    rchk(8'h0C, 32'h81);
    apb(1'b1, 8'h48, 32'h1);
    apb(1'b1, 8'h00, 32'h3);
    rchk(8'h00, 32'h1);
    // Huge delays loaded: any wait would hit the timeout
    wait_ctrl(32'h80);
    chk({31'h0, conv_power}, 32'h0);
    chk(n_rst, 32'h1);
    rchk(8'h08, 32'h81);
    rchk(8'h14, {22'h0, 3'd0, 7'h55});
    rchk(8'h30, {22'h0, 3'd7, 7'h55});
    rchk(8'h18, 32'h0);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h48, 32'h0);
    rchk(8'h40, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h44, 32'h1);
    rchk(8'h40, 32'h0);
    apb(1'b1, 8'h08, 32'h1);
    rchk(8'h08, 32'h80);
    apb(1'b1, 8'h00, 32'h81);
    rchk(8'h00, 32'h1);
    lat <= 8'h02;
    apb(1'b1, 8'h04, 32'h0003_0005);
    apb(1'b1, 8'h10, 32'h2);
    apb(1'b1, 8'h00, 32'h5);
    t0 = cyc;
    wait_start;
    t1 = cyc;
    chk({29'h0, conv_channel}, 32'h1);
    chk({31'h0, conv_power}, 32'h1);
    chk(32'(t1 - t0 >= 20 && t1 - t0 <= 28), 32'h1);
    wait_start;
    chk(32'(cyc - t1 >= 12 && cyc - t1 <= 30), 32'h1);
    wait_ctrl(32'h20);
    apb(1'b1, 8'h00, 32'h1);
    repeat (40) @(posedge mclk);
    t0 = 0;
    repeat (60) begin
      @(posedge mclk);
      t0 += (conv_start === 1'b1);
    end
    chk(t0, 32'h0);
    // Soft reset and power saver off; repeat-done cleared by W1C
    apb(1'b1, 8'h00, 32'h39);
    rchk(8'h00, 32'h19);
    chk({30'h0, conv_power, core_reset}, 32'h3);
    apb(1'b1, 8'h00, 32'h1);
    rchk(8'h00, 32'h1);
    chk({30'h0, conv_power, core_reset}, 32'h0);
    end_sim;
  end
endmodule

bind adsq_regs adsq_regs_asserts #(.ADDR_W(ADDR_W)) u_chk (.mclk(mclk),
  .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv_start(conv_start), .conv_channel(conv_channel),
  .conv_power(conv_power));

// [adsq_tick.sv]
`timescale 1ns/10ps
`include "adsq_defs.svh"
module adsq_tick #(
  parameter int TICK_CYC = `ADSQ_TICK_CYC
) (
  input  wire logic  mclk,  // Functional clock
  input  wire logic  nrst,  // Async reset, active low
  adsq_tick_if.gen   tk     // Restart in, tick out
);
  import adsq_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } adsq_tick_st_t;

  adsq_tick_st_t s_r;
  adsq_tick_st_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (tk.restart) begin
      s_nxt.cnt = 16'h0000;
    end else if (s_r.cnt == 16'(TICK_CYC - 1)) begin
      s_nxt.cnt  = 16'h0000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tk.tick = s_r.tick;
endmodule

// [adsq_tick_if.sv]
`timescale 1ns/10ps
interface adsq_tick_if;
  logic restart;
  logic tick;
  modport seq (output restart, input tick);
  modport gen (input restart, output tick);
endinterface
